// ===== pmt_pkg.sv
// types shared by the period match timer
package pmt_pkg;

  // prescale selection decoded from the control field
  typedef enum logic [1:0] {
    PMT_PRE_DIV1,
    PMT_PRE_DIV4,
    PMT_PRE_DIV16
  } pmt_pre_mode_t;

  // control register image
  typedef struct packed {
    logic [3:0] postscale_select;
    logic timer_on;
    logic [1:0] prescale_select;
  } pmt_ctrl_t;

  // register bus request
  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } pmt_bus_req_t;

endpackage : pmt_pkg

// ===== pmt_regs.svh
// register offsets, field positions, reset values and timing constants of the period match timer
`ifndef PMT_REGS_SVH
`define PMT_REGS_SVH

// register word addresses
`define PMT_ADDR_COUNT 4'h0
`define PMT_ADDR_LIMIT 4'h1
`define PMT_ADDR_CTRL 4'h2
`define PMT_ADDR_FLAGS 4'h3
`define PMT_ADDR_ENABLES 4'h4
`define PMT_ADDR_STATUS 4'h5

// control register fields
`define PMT_CTRL_ON_BIT 2
`define PMT_CTRL_PRE_LSB 0
`define PMT_CTRL_POST_LSB 3
`define PMT_CTRL_MASK 8'h7f

// reset values
`define PMT_COUNT_RST 8'h00
`define PMT_LIMIT_RST 8'hff
`define PMT_CTRL_RST 8'h00

// prescale and instruction clock terminal counts
`define PMT_PRE_DIV1_LAST 4'h0
`define PMT_PRE_DIV4_LAST 4'h3
`define PMT_PRE_DIV16_LAST 4'hf
`define PMT_INSTR_DIV 2'h3

`endif

// ===== pmt_scaler.sv
// clearable modulo counter used for prescale and postscale stages
`timescale 1ns/1ps

module pmt_scaler #(
  parameter int WIDTH = 4
) (
  input wire logic clk_i, // system clock
  input wire logic rstn_i, // synchronous reset, active low
  input wire logic clear_i, // clear count
  input wire logic step_i, // advance one
  input wire logic [WIDTH-1:0] last_i, // terminal count value
  output logic tick_o // terminal count reached on this step
);

  logic [WIDTH-1:0] cnt_r;
  logic [WIDTH-1:0] cnt_nxt;

  // elaboration check on width
  if (WIDTH < 1)
  begin : g_bad_width
    $error("pmt_scaler width must be at least one");
  end

  // terminal count detection
  assign tick_o = step_i && (cnt_r == last_i);

  // next count
  always_comb
  begin
    cnt_nxt = cnt_r;
    if (clear_i)
    begin
      cnt_nxt = '0;
    end
    else if (tick_o)
    begin
      cnt_nxt = '0;
    end
    else if (step_i)
    begin
      cnt_nxt = cnt_r + WIDTH'(1);
    end
  end

  // count register
  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
    begin
      cnt_r <= '0;
    end
    else
    begin
      cnt_r <= cnt_nxt;
    end
  end

endmodule : pmt_scaler

// ===== pmt_sink.sv
// downstream peripheral counting match pulses
`timescale 1ns/1ps
module pmt_sink (
  input wire logic clk_i, // clock
  input wire logic match_i, // match pulse
  output int unsigned count_o // pulses seen
);
  // one count per synchronous pulse
  initial count_o = 0;
  always @(posedge clk_i)
  begin
    if (match_i)
    begin
      count_o <= count_o + 1;
    end
  end
endmodule : pmt_sink

// ===== pmt_timer.sv
// period match timer with prescaler, postscaler and match interrupt
`timescale 1ns/1ps
`include "pmt_regs.svh"

////////////////////////////////////////////////////////////////////////////////
// Overview of operation
// - the timer counts only on the instruction clock, the system clock divided by four.
// - the 8-bit count register advances by one on each prescaled tick starting from zero.
// - a 4-bit prescale counter gives pass-through, divide by four and divide by sixteen.
// - every cycle the count is compared with the period and, while the timer runs, equality raises the match signal.
// - after a match the count returns to zero on the next prescaled tick instead of counting on.
// - each match steps a 4-bit postscale counter whose terminal count is the interrupt event.
// - count and period are read and writable, and reset gives count zero and period all ones.
// - count writes, control writes and every reset cause clear the prescale and postscale counters.
// - a control write leaves the count value untouched.
// - the postscale event sets a latched match flag in the interrupt flag register.
// - the match interrupt reaches the output only while its enable bit is set.
// - a 4-bit postscale field chooses ratios from one to sixteen matches per interrupt.
// - the match signal is exported for neighbouring peripherals.
// - the exported match signal is registered in the system clock domain.
// - while the processor sleeps the timer stops and count and period hold.
module pmt_timer
  import pmt_pkg::*;
#(
  parameter int COUNT_W = 8,
  parameter int SCALE_W = 4
) (
  input wire logic clk_i, // system clock, 100 MHz
  input wire logic rstn_i, // synchronous reset, active low
  input wire logic reset_cause_i, // any other device reset cause, active high
  input wire logic sleep_i, // processor asleep
  input pmt_pkg::pmt_bus_req_t bus_i, // register bus request
  output logic [7:0] rdata_o, // read data, one cycle after read strobe
  output logic period_match_pulse_o, // registered match pulse
  output logic irq_o // level interrupt
);
  import pmt_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////
  // elaboration checks
  if (COUNT_W != 8)
  begin : g_bad_count
    $error("count width must be 8 to fit the byte bus");
  end
  if (SCALE_W != 4)
  begin : g_bad_scale
    $error("scaler width must be 4");
  end

  ////////////////////////////////////////////////////////////////////////////////
  // state
  logic [7:0] count_r, count_nxt;
  logic [7:0] limit_r, limit_nxt;
  pmt_ctrl_t ctrl_r, ctrl_nxt;
  logic flag_r, flag_nxt;
  logic enable_r, enable_nxt;
  logic [1:0] instr_r, instr_nxt;
  logic match_d_r, match_d_nxt;
  logic pulse_r, pulse_nxt;
  logic [7:0] rdata_r, rdata_nxt;
  logic scaler_clr;
  logic instr_tick;
  logic pre_tick;
  logic post_tick;
  logic match;
  logic run;
  logic wr_count, wr_limit, wr_ctrl, wr_flags, wr_enables;
  logic [3:0] pre_last;
  pmt_pre_mode_t pre_mode;

  // write decode
  assign wr_count = bus_i.wr && (bus_i.addr == `PMT_ADDR_COUNT);
  assign wr_limit = bus_i.wr && (bus_i.addr == `PMT_ADDR_LIMIT);
  assign wr_ctrl = bus_i.wr && (bus_i.addr == `PMT_ADDR_CTRL);
  assign wr_flags = bus_i.wr && (bus_i.addr == `PMT_ADDR_FLAGS);
  assign wr_enables = bus_i.wr && (bus_i.addr == `PMT_ADDR_ENABLES);

  // scaler clear on count write, control write and reset causes
  assign scaler_clr = wr_count || wr_ctrl || reset_cause_i;
  assign run = ctrl_r.timer_on && !sleep_i;

  ////////////////////////////////////////////////////////////////////////////////
  // prescale decode
  always_comb
  begin
    unique case (ctrl_r.prescale_select)
      2'h0: pre_mode = PMT_PRE_DIV1;
      2'h1: pre_mode = PMT_PRE_DIV4;
      2'h2: pre_mode = PMT_PRE_DIV16;
      2'h3: pre_mode = PMT_PRE_DIV16;
    endcase
    unique case (pre_mode)
      PMT_PRE_DIV1: pre_last = `PMT_PRE_DIV1_LAST;
      PMT_PRE_DIV4: pre_last = `PMT_PRE_DIV4_LAST;
      PMT_PRE_DIV16: pre_last = `PMT_PRE_DIV16_LAST;
    endcase
  end

  // instruction clock enable, system clock divided by four
  assign instr_tick = run && (instr_r == `PMT_INSTR_DIV);

  // prescale counter
  pmt_scaler #(
    .WIDTH(SCALE_W)
  ) u_prescale (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .clear_i(scaler_clr),
    .step_i(instr_tick),
    .last_i(pre_last),
    .tick_o(pre_tick)
  );

  // compare on every system clock cycle while running
  assign match = run && (count_r == limit_r);

  // postscale counter stepped once per match
  pmt_scaler #(
    .WIDTH(SCALE_W)
  ) u_postscale (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .clear_i(scaler_clr),
    .step_i(match && pre_tick),
    .last_i(ctrl_r.postscale_select),
    .tick_o(post_tick)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // next state of timer and registers
  always_comb
  begin
    count_nxt = count_r;
    limit_nxt = limit_r;
    ctrl_nxt = ctrl_r;
    flag_nxt = flag_r;
    enable_nxt = enable_r;
    instr_nxt = instr_r;
    match_d_nxt = match_d_r;
    pulse_nxt = 1'b0;
    rdata_nxt = rdata_r;
    if (run)
    begin
      instr_nxt = instr_r + 2'h1;
    end
    if (pre_tick)
    begin
      match_d_nxt = match;
      if (match)
      begin
        count_nxt = `PMT_COUNT_RST;
      end
      else
      begin
        count_nxt = count_r + 8'h01;
      end
      pulse_nxt = match;
    end
    if (wr_count)
    begin
      count_nxt = bus_i.wdata;
    end
    if (wr_limit)
    begin
      limit_nxt = bus_i.wdata;
    end
    if (wr_ctrl)
    begin
      ctrl_nxt = pmt_ctrl_t'(bus_i.wdata[6:0]);
    end
    if (wr_enables)
    begin
      enable_nxt = bus_i.wdata[0];
    end
    // write one clears, hardware set wins
    if (wr_flags && bus_i.wdata[0])
    begin
      flag_nxt = 1'b0;
    end
    if (post_tick)
    begin
      flag_nxt = 1'b1;
    end
    // read data for the next cycle
    if (bus_i.rd)
    begin
      unique case (bus_i.addr)
        `PMT_ADDR_COUNT: rdata_nxt = count_r;
        `PMT_ADDR_LIMIT: rdata_nxt = limit_r;
        `PMT_ADDR_CTRL: rdata_nxt = {1'b0, ctrl_r};
        `PMT_ADDR_FLAGS: rdata_nxt = {7'h00, flag_r};
        `PMT_ADDR_ENABLES: rdata_nxt = {7'h00, enable_r};
        `PMT_ADDR_STATUS: rdata_nxt = {6'h00, match_d_r, run};
        default: rdata_nxt = 8'h00;
      endcase
    end
    else
    begin
      rdata_nxt = 8'h00;
    end
  end

  // registers, reset also clears on other reset causes
  always_ff @(posedge clk_i)
  begin
    if (!rstn_i || reset_cause_i)
    begin
      count_r <= `PMT_COUNT_RST;
      limit_r <= `PMT_LIMIT_RST;
      ctrl_r <= pmt_ctrl_t'(`PMT_CTRL_RST);
      flag_r <= 1'b0;
      enable_r <= 1'b0;
      instr_r <= 2'h0;
      match_d_r <= 1'b0;
      pulse_r <= 1'b0;
      rdata_r <= 8'h00;
    end
    else
    begin
      count_r <= count_nxt;
      limit_r <= limit_nxt;
      ctrl_r <= ctrl_nxt;
      flag_r <= flag_nxt;
      enable_r <= enable_nxt;
      instr_r <= instr_nxt;
      match_d_r <= match_d_nxt;
      pulse_r <= pulse_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // outputs
  assign rdata_o = rdata_r;
  assign period_match_pulse_o = pulse_r;
  assign irq_o = flag_r && enable_r;

endmodule : pmt_timer

// ===== pmt_timer_sva.sv
// port assertions of the period match timer
`timescale 1ns/1ps
module pmt_timer_sva
  import pmt_pkg::*;
(
  input wire logic clk_i, // clock
  input wire logic rstn_i, // reset
  input wire logic reset_cause_i, // other resets
  input wire logic sleep_i, // asleep
  input pmt_pkg::pmt_bus_req_t bus_i, // bus
  input wire logic [7:0] rdata_o, // read data
  input wire logic period_match_pulse_o, // match
  input wire logic irq_o // interrupt
);
  default clocking @(posedge clk_i);
  endclocking
  default disable iff (!rstn_i);
  logic on_m;
  // shadow of the timer on bit, updated at the edge that takes the write
  always_ff @(posedge clk_i)
  begin
    if (!rstn_i || reset_cause_i)
    begin
      on_m <= 1'b0;
    end
    else if (bus_i.wr && bus_i.addr == 4'h2)
    begin
      on_m <= bus_i.wdata[2];
    end
  end
  ////////////////////////////////////////
  // pulses, reads and the interrupt level
  pulse_gap_a: assert property (period_match_pulse_o |=> !period_match_pulse_o [*3])
    else $error("match pulses too close");
  rd_idle_a: assert property (!bus_i.rd |=> rdata_o == 8'h00)
    else $error("read data without read");
  unmap_rd_a: assert property (bus_i.rd && bus_i.addr > 4'h5 |=> rdata_o == 8'h00)
    else $error("unmapped read not zero");
  sleep_quiet_a: assert property (sleep_i |=> !period_match_pulse_o)
    else $error("match while asleep");
  cause_clear_a: assert property (reset_cause_i |=> !period_match_pulse_o && !irq_o)
    else $error("reset cause left outputs");
  off_quiet_a: assert property (period_match_pulse_o |-> $past(on_m))
    else $error("match while stopped");
  irq_rise_a: assert property ($rose(irq_o) |-> $past(bus_i.wr) || period_match_pulse_o
    || $past(period_match_pulse_o) || $past(period_match_pulse_o, 2))
    else $error("interrupt without cause");
  irq_fall_a: assert property ($fell(irq_o) |-> $past(bus_i.wr) || $past(reset_cause_i))
    else $error("interrupt dropped alone");
  cover property (period_match_pulse_o);
  cover property ($rose(irq_o));
  cover property (reset_cause_i);
endmodule : pmt_timer_sva

// ===== tb.sv
// testbench of the period match timer
`timescale 1ns/1ps
module tb;
  import pmt_pkg::*;
  logic clk_i = 0;
  logic rstn_i = 0;
  logic reset_cause_i = 0;
  logic sleep_i = 0;
  pmt_bus_req_t bus_i = '0;
  logic [7:0] rdata_o;
  logic period_match_pulse_o;
  logic irq_o;
  int unsigned cnt;
  int err_count = 0;
  int checks = 0;
  int cyc = 0;
  int n;
  int c0;
  ////////////////////////////////////////
  // clock, design and peripheral
  initial forever #5 clk_i = ~clk_i;
  pmt_timer u_pmt_timer (.clk_i(clk_i), .rstn_i(rstn_i), .reset_cause_i(reset_cause_i),
    .sleep_i(sleep_i), .bus_i(bus_i), .rdata_o(rdata_o),
    .period_match_pulse_o(period_match_pulse_o), .irq_o(irq_o));
  pmt_sink u_pmt_sink (.clk_i(clk_i), .match_i(period_match_pulse_o), .count_o(cnt));
  ////////////////////////////////////////
  // bus and compare tasks
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_i);
    bus_i <= '{a, d, 1'b1, 1'b0};
    @(posedge clk_i);
    bus_i <= '0;
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk_i);
    bus_i <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge clk_i);
    bus_i <= '0;
    #1;
    chk(rdata_o, e);
  endtask : rd
  task automatic wp();
    n = 0;
    do
    begin
      @(posedge clk_i);
      #1;
      n++;
    end
    while (!period_match_pulse_o && n < 5000);
  endtask : wp
  task automatic gap(input int e);
    wp();
    wp();
    chk(16'(n), 16'(e));
  endtask : gap
  task automatic stop_test();
    $display("checks %0d errors %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
    begin
      $display("RESULT: PASS");
    end
    else
    begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : stop_test
  // hang guard
  always @(posedge clk_i)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      err_count++;
      stop_test();
    end
  end
  ////////////////////////////////////////
  // test sequence
  initial
  begin
    repeat (3) @(posedge clk_i);
    rstn_i <= 1'b1;
    rd(4'h0, 8'h00);
    rd(4'h1, 8'hff);
    rd(4'h7, 8'h00);
    wr(4'h1, 8'h03);
    rd(4'h1, 8'h03);
    wr(4'h4, 8'h01);
    for (int p = 0; p < 4; p++)
    begin
      wr(4'h2, 8'h04 | 8'(p));
      gap(16 * (p == 0 ? 1 : p == 1 ? 4 : 16));
    end
    wr(4'h2, 8'h00);
    wr(4'h0, 8'h02);
    wr(4'h2, 8'h00);
    rd(4'h0, 8'h02);
    chk(irq_o, 1'b1);
    wr(4'h4, 8'h00);
    #1;
    chk(irq_o, 1'b0);
    wr(4'h4, 8'h01);
    #1;
    chk(irq_o, 1'b1);
    wr(4'h3, 8'h01);
    #1;
    chk(irq_o, 1'b0);
    c0 = cnt;
    wr(4'h2, 8'h04);
    sleep_i <= 1'b1;
    repeat (40) @(posedge clk_i);
    sleep_i <= 1'b0;
    chk(16'(cnt - c0), 16'h0000);
    for (int q = 0; q < 16; q += 5)
    begin
      wr(4'h2, 8'h00);
      wr(4'h3, 8'h01);
      c0 = cnt;
      wr(4'h2, 8'(q * 8) | 8'h04);
      n = 0;
      while (irq_o !== 1'b1 && n < 1000)
      begin
        @(posedge clk_i);
        #1;
        n++;
      end
      @(posedge clk_i);
      #1;
      chk(16'(cnt - c0), 16'(q + 1));
    end
    @(posedge clk_i);
    reset_cause_i <= 1'b1;
    @(posedge clk_i);
    reset_cause_i <= 1'b0;
    rd(4'h1, 8'hff);
    rd(4'h0, 8'h00);
    rd(4'h2, 8'h00);
    chk(irq_o, 1'b0);
    stop_test();
  end
endmodule : tb
bind pmt_timer pmt_timer_sva u_pmt_timer_sva (.clk_i(clk_i), .rstn_i(rstn_i),
  .reset_cause_i(reset_cause_i), .sleep_i(sleep_i), .bus_i(bus_i), .rdata_o(rdata_o),
  .period_match_pulse_o(period_match_pulse_o), .irq_o(irq_o));
